// ===== serial_port_pkg.sv
// Shared constants and types of the serial port block.
package serial_port_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W               = 8;
  localparam logic [7:0]  SERIAL_CONTROL_ADDR  = 8'h98;
  localparam logic [7:0]  DATA_ADDR            = 8'ha0;
  localparam logic [7:0]  POWER_CONTROL_ADDR   = 8'ha4;
  localparam logic [7:0]  BAUD_ADDR            = 8'ha8;
  localparam logic [7:0]  BIT_ACCESS_ADDR      = 8'hac;
  localparam logic [7:0]  SERIAL_CONTROL_RESET = 8'h00;
  localparam logic [15:0] BAUD_DIV_RESET       = 16'h0036;
  localparam logic [1:0]  RESP_OKAY            = 2'h0;
  localparam logic [1:0]  RESP_SLVERR          = 2'h2;

  // ==========================================================================
  // Field positions
  localparam int RX_DONE_POS       = 0;
  localparam int TX_DONE_POS       = 1;
  localparam int RX_NINTH_POS      = 2;
  localparam int TX_NINTH_POS      = 3;
  localparam int RX_ENABLE_POS     = 4;
  localparam int MULTIPROC_POS     = 5;
  localparam int MODE_LOW_POS      = 6;
  localparam int MODE_HIGH_POS     = 7;
  localparam int DOUBLE_RATE_POS   = 0;
  localparam int FRAMING_CHECK_POS = 6;
  localparam int BAUD_DOUBLE_POS   = 7;

  // ==========================================================================
  // Modes, rates and frame counts
  localparam logic [1:0]  MODE_SHIFT       = 2'h0;
  localparam logic [1:0]  MODE_UART8       = 2'h1;
  localparam logic [1:0]  MODE_UART9_FIXED = 2'h2;
  localparam logic [15:0] MODE0_DIV        = 16'h000c;
  localparam logic [15:0] MODE0_DIV_X2     = 16'h0006;
  localparam logic [15:0] MODE2_DIV_SLOW   = 16'h0040;
  localparam logic [15:0] MODE2_DIV_FAST   = 16'h0020;
  localparam int          OVERSAMPLE_LOG2  = 4;
  localparam logic [3:0]  OVERSAMPLE_LAST  = 4'hf;
  localparam logic [3:0]  MID_TICK         = 4'h7;
  localparam logic [3:0]  FRAME_8          = 4'h9;
  localparam logic [3:0]  FRAME_9          = 4'ha;
  localparam logic [3:0]  M0_LAST          = 4'h7;

  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

endpackage

// ===== bit_timer.sv
// Free-running divider that gives one enable pulse every divisor cycles.
`timescale 1ns/10ps
module bit_timer #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         clear,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_t;

  timer_t s;
  timer_t next_s;

  // A divisor of zero acts as one, so the pulse never stops.
  assign tick = !clear && ((divisor <= W'(1)) || (s.cnt >= divisor - W'(1)));

  // The count restarts on clear, so the first pulse lands a full period on.
  always_comb begin
    next_s = s;
    if (clear || tick) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// ===== serial_port_with_framing_check.sv
// Serial port with shift mode, three UART modes and a framing check.
// What this block does
// RL1: Shift mode plus three full-duplex UART modes.
// RL2: Transmitter and receiver run independently, own rates except fixed mode 2.
// RL3: Framing check only async, only when enabled.
// RL4: Invalid stop bit sets framing error flag.
// RL5: Framing error clears only by write or reset.
// RL6: With check on, receive done at stop.
// RL7: Control bit 7 is error flag or mode.
// RL8: Two mode bits pick one of four modes.
// RL9: Mode 0 rate clock/12, or /6 doubled.
// RL10: Mode 2 rate /64 or /32, halved doubled.
// RL11: Multiprocessor bit gates reception in 9-bit modes.
// RL12: Receiver accepts data only while enabled.
// RL13: Ninth transmitted bit comes from control bit.
// RL14: Store ninth bit, or stop bit mode 1 with multiprocessor bit clear.
// RL15: Transmit done at bit 8 or stop start.
// RL16: Receive done at end of bit 8, mode 0.
// RL17: Control register resets to zero, bit access.
// RL18: Interrupt request while either done flag set.
`timescale 1ns/10ps
module serial_port_with_framing_check
  import serial_port_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              rxdIn,
  output logic                   rxdOut,
  output logic                   rxdOe,
  output logic                   txdOut,
  output logic                   serialIrq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic              awReady;
    logic              wReady;
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic              fe;
    logic              msHigh;
    logic              msLow;
    logic              mpe;
    logic              ren;
    logic              txNinth;
    logic              rxNinth;
    logic              ti;
    logic              ri;
    logic              fce;
    logic              baudDouble;
    logic              x2;
    logic [15:0]       txDiv;
    logic [15:0]       rxDiv;
    logic [7:0]        rxBuf;
    tx_state_t         txState;
    logic              m0Recv;
    logic              m0High;
    logic [9:0]        txShift;
    logic [3:0]        txLeft;
    logic [3:0]        txSub;
    logic              txd;
    logic              rxdOut;
    logic              rxdOe;
    rx_state_t         rxState;
    logic [3:0]        rxSub;
    logic [3:0]        rxLeft;
    logic [8:0]        rxShift;
    logic [2:0]        rxSync;
    logic              rxLine;
    logic              irq;
  } state_t;

  state_t      s;
  state_t      next_s;
  logic [1:0]  mode;
  logic [7:0]  scValue;
  logic [15:0] fixedDiv;
  logic [15:0] txRate;
  logic [15:0] rxRate;
  logic        txTick;
  logic        rxTick;
  logic        ctlWrite;
  logic [7:0]  ctlByte;
  logic        dataWrite;
  logic        dataLast;
  logic        stopSample;
  logic [8:0]  rxNew;
  logic        rxAccept;

  // ==========================================================================
  // Mode decode and bit rates
  // RL8: mode from two bits
  assign mode = {s.msHigh, s.msLow};
  // RL7: bit 7 view depends on check enable
  assign scValue = {s.fce ? s.fe : s.msHigh, s.msLow, s.mpe, s.ren,
                    s.txNinth, s.rxNinth, s.ti, s.ri};
  // RL10: fixed mode 2 oversample divisor
  assign fixedDiv = ((s.baudDouble ? MODE2_DIV_FAST : MODE2_DIV_SLOW)
                     >> s.x2) >> OVERSAMPLE_LOG2;
  // RL9: mode 0 counts half bits to shape the shift clock
  assign txRate = (mode == MODE_SHIFT) ?
                  ((s.x2 ? MODE0_DIV_X2 : MODE0_DIV) >> 1) :
                  (mode == MODE_UART9_FIXED) ? fixedDiv : s.txDiv;
  // RL2: receiver has its own divisor
  assign rxRate = (mode == MODE_UART9_FIXED) ? fixedDiv : s.rxDiv;

  // Separate timers, so both directions run at once at different rates.
  bit_timer #(.W(16)) txTimer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clear    (s.txState == TX_IDLE),
    .divisor  (txRate),
    .tick     (txTick)
  );

  bit_timer #(.W(16)) rxTimer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clear    (s.rxState == RX_IDLE),
    .divisor  (rxRate),
    .tick     (rxTick)
  );

  // ==========================================================================
  // Next state: bus slave first, then the engines, so a set wins a clear.
  always_comb begin
    next_s     = s;
    ctlWrite   = 1'b0;
    ctlByte    = scValue;
    dataWrite  = 1'b0;
    dataLast   = 1'b0;
    stopSample = 1'b0;
    rxNew      = s.rxShift;
    rxAccept   = 1'b0;
    if (awvalid && s.awReady) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wReady) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end
    if (s.awHeld && s.wHeld && !s.bValid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = RESP_OKAY;
      if (s.awAddr == SERIAL_CONTROL_ADDR) begin
        ctlWrite = s.wStrb[0];
        ctlByte  = s.wData[7:0];
      end else if (s.awAddr == DATA_ADDR) begin
        dataWrite = s.wStrb[0];
      end else if (s.awAddr == POWER_CONTROL_ADDR) begin
        if (s.wStrb[0]) begin
          next_s.fce        = s.wData[FRAMING_CHECK_POS];
          next_s.baudDouble = s.wData[BAUD_DOUBLE_POS];
          next_s.x2         = s.wData[DOUBLE_RATE_POS];
        end
      end else if (s.awAddr == BAUD_ADDR) begin
        if (s.wStrb[0]) next_s.txDiv[7:0]  = s.wData[7:0];
        if (s.wStrb[1]) next_s.txDiv[15:8] = s.wData[15:8];
        if (s.wStrb[2]) next_s.rxDiv[7:0]  = s.wData[23:16];
        if (s.wStrb[3]) next_s.rxDiv[15:8] = s.wData[31:24];
      end else if (s.awAddr == BIT_ACCESS_ADDR) begin
        // RL17: single-bit access to the control register
        ctlWrite                 = s.wStrb[0];
        ctlByte[s.wData[2:0]]    = s.wData[3];
      end else begin
        next_s.bResp = RESP_SLVERR;
      end
    end
    next_s.awReady = !next_s.awHeld;
    next_s.wReady  = !next_s.wHeld;

    // Read channel; one answer stands until it is taken.
    if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
    end
    if (arvalid && s.arReady) begin
      next_s.rValid = 1'b1;
      next_s.rResp  = RESP_OKAY;
      next_s.rData  = '0;
      if (araddr == SERIAL_CONTROL_ADDR || araddr == BIT_ACCESS_ADDR) begin
        next_s.rData[7:0] = scValue;
      end else if (araddr == DATA_ADDR) begin
        next_s.rData[7:0] = s.rxBuf;
      end else if (araddr == POWER_CONTROL_ADDR) begin
        next_s.rData[FRAMING_CHECK_POS] = s.fce;
        next_s.rData[BAUD_DOUBLE_POS]   = s.baudDouble;
        next_s.rData[DOUBLE_RATE_POS]   = s.x2;
      end else if (araddr == BAUD_ADDR) begin
        next_s.rData = {s.rxDiv, s.txDiv};
      end else begin
        next_s.rResp = RESP_SLVERR;
      end
    end
    next_s.arReady = !next_s.rValid;

    // RL7: bit 7 written as error flag or as mode bit
    if (ctlWrite) begin
      // RL5: only a write clears the error flag
      if (s.fce) begin
        next_s.fe = ctlByte[MODE_HIGH_POS];
      end else begin
        next_s.msHigh = ctlByte[MODE_HIGH_POS];
      end
      next_s.msLow   = ctlByte[MODE_LOW_POS];
      next_s.mpe     = ctlByte[MULTIPROC_POS];
      next_s.ren     = ctlByte[RX_ENABLE_POS];
      next_s.txNinth = ctlByte[TX_NINTH_POS];
      next_s.rxNinth = ctlByte[RX_NINTH_POS];
      next_s.ti      = ctlByte[TX_DONE_POS];
      next_s.ri      = ctlByte[RX_DONE_POS];
    end

    // Transmitter, which also runs the mode 0 shift in both directions.
    case (s.txState)
      TX_IDLE: begin
        next_s.txSub  = '0;
        next_s.m0High = 1'b0;
        // RL1: a data write starts the frame of the current mode
        if (dataWrite) begin
          next_s.txState = TX_SHIFT;
          next_s.m0Recv  = 1'b0;
          next_s.txd     = 1'b0;
          if (mode == MODE_SHIFT) begin
            next_s.txShift = {2'h3, s.wData[7:0]};
            next_s.rxdOut  = s.wData[0];
            next_s.rxdOe   = 1'b1;
            next_s.txLeft  = M0_LAST;
          end else begin
            // RL13: ninth bit from the control register
            next_s.txShift = {1'b1, mode[1] ? s.txNinth : 1'b1, s.wData[7:0]};
            next_s.txLeft  = mode[1] ? FRAME_9 : FRAME_8;
          end
        end else if (mode == MODE_SHIFT && s.ren && !s.ri) begin
          // RL12: shift reception only while enabled
          next_s.txState = TX_SHIFT;
          next_s.m0Recv  = 1'b1;
          next_s.txd     = 1'b0;
          next_s.rxdOe   = 1'b0;
          next_s.txLeft  = M0_LAST;
        end
      end
      TX_SHIFT: begin
        if (txTick && mode == MODE_SHIFT) begin
          if (!s.m0High) begin
            // Data is sampled on the rising shift clock.
            next_s.txd    = 1'b1;
            next_s.m0High = 1'b1;
            if (s.m0Recv) begin
              next_s.txShift = {2'h3, s.rxLine, s.txShift[7:1]};
            end
          end else begin
            next_s.m0High = 1'b0;
            if (s.txLeft == '0) begin
              next_s.txState = TX_IDLE;
              next_s.rxdOe   = 1'b0;
              // RL16: receive done at end of bit 8
              if (s.m0Recv) begin
                next_s.ri    = 1'b1;
                next_s.rxBuf = s.txShift[7:0];
              end else begin
                // RL15: transmit done at end of bit 8
                next_s.ti = 1'b1;
              end
            end else begin
              next_s.txd    = 1'b0;
              next_s.txLeft = s.txLeft - 4'h1;
              if (!s.m0Recv) begin
                next_s.txShift = {1'b1, s.txShift[9:1]};
                next_s.rxdOut  = s.txShift[1];
              end
            end
          end
        end else if (txTick) begin
          next_s.txSub = s.txSub + 4'h1;
          if (s.txSub == OVERSAMPLE_LAST) begin
            if (s.txLeft == '0) begin
              next_s.txState = TX_IDLE;
            end else begin
              next_s.txd     = s.txShift[0];
              next_s.txShift = {1'b1, s.txShift[9:1]};
              next_s.txLeft  = s.txLeft - 4'h1;
              // RL15: transmit done as the stop bit starts
              if (s.txLeft == 4'h1) next_s.ti = 1'b1;
            end
          end
        end
      end
      default: next_s.txState = TX_IDLE;
    endcase

    // Line filter: the first stage feeds only the second.
    next_s.rxSync = {s.rxSync[1:0], rxdIn};
    if (s.rxSync[1] == s.rxSync[2]) begin
      next_s.rxLine = s.rxSync[2];
    end

    // Asynchronous receiver, sampling mid-bit at sixteen ticks a bit.
    case (s.rxState)
      RX_IDLE: begin
        next_s.rxSub = '0;
        // RL12: start edge counts only while enabled
        if (s.ren && mode != MODE_SHIFT && s.rxLine && !next_s.rxLine) begin
          next_s.rxState = RX_START;
        end
      end
      RX_START: begin
        if (rxTick) begin
          next_s.rxSub = s.rxSub + 4'h1;
          if (s.rxSub == MID_TICK) begin
            // A start bit gone high by mid-bit was a glitch.
            next_s.rxSub   = '0;
            next_s.rxState = s.rxLine ? RX_IDLE : RX_BITS;
            next_s.rxLeft  = mode[1] ? FRAME_9 : FRAME_8;
          end
        end
      end
      RX_BITS: begin
        if (rxTick) begin
          next_s.rxSub = s.rxSub + 4'h1;
          if (s.rxSub == OVERSAMPLE_LAST) begin
            next_s.rxLeft = s.rxLeft - 4'h1;
            if (s.rxLeft != 4'h1) begin
              rxNew          = {s.rxLine, s.rxShift[8:1]};
              next_s.rxShift = rxNew;
              dataLast       = (s.rxLeft == 4'h2);
            end else begin
              stopSample     = 1'b1;
              next_s.rxState = RX_IDLE;
            end
          end
        end
      end
      default: next_s.rxState = RX_IDLE;
    endcase

    // RL6: completion point moves to the stop bit with the check on
    if ((dataLast && !s.fce) || (stopSample && s.fce)) begin
      // RL11: multiprocessor bit keeps frames whose ninth bit is high
      rxAccept = !s.ri && (!s.mpe || (mode[1] ? rxNew[8] :
                                      (stopSample ? s.rxLine : 1'b1)));
      if (rxAccept) begin
        next_s.ri    = 1'b1;
        next_s.rxBuf = mode[1] ? rxNew[7:0] : rxNew[8:1];
        // RL14: received ninth bit in 9-bit modes
        if (mode[1]) next_s.rxNinth = rxNew[8];
      end
    end
    if (stopSample) begin
      // RL3: stop check only when enabled; RL4: bad stop sets flag
      if (s.fce && !s.rxLine) next_s.fe = 1'b1;
      // RL14: mode 1 keeps the stop bit while the multiprocessor bit is clear
      if (mode == MODE_UART8 && !s.mpe) next_s.rxNinth = s.rxLine;
    end

    // RL18: request while either done flag stands
    next_s.irq = s.ti | s.ri;
  end

  // RL17: control fields clear to zero on reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s        <= '0;
      s.txd    <= 1'b1;
      s.rxLine <= 1'b1;
      s.rxSync <= '1;
      s.txDiv  <= BAUD_DIV_RESET;
      s.rxDiv  <= BAUD_DIV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes straight from the state register.
  assign awready   = s.awReady;
  assign wready    = s.wReady;
  assign bresp     = s.bResp;
  assign bvalid    = s.bValid;
  assign arready   = s.arReady;
  assign rdata     = s.rData;
  assign rresp     = s.rResp;
  assign rvalid    = s.rValid;
  assign txdOut    = s.txd;
  assign rxdOut    = s.rxdOut;
  assign rxdOe     = s.rxdOe;
  assign serialIrq = s.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_fe_sticky: assert property ( // RL5
    s.fe && !ctlWrite |=> s.fe)
    else $error("Framing error flag dropped without a write.");
  a_rx_needs_enable: assert property ( // RL12
    s.rxState == RX_IDLE && !s.ren |=> s.rxState == RX_IDLE)
    else $error("Receiver started while disabled.");
  a_fe_bad_stop: assert property ( // RL4
    stopSample && s.fce && !s.rxLine |=> s.fe)
    else $error("Invalid stop bit did not set the error flag.");
  a_ri_at_stop: assert property ( // RL6
    $rose(s.ri) && s.fce && mode != MODE_SHIFT |-> $past(stopSample))
    else $error("Receive done not raised at the stop bit.");
  a_mode0_half_bit: assert property ( // RL9
    $fell(s.txd) && mode == MODE_SHIFT && !s.x2 |->
    (!s.txd) [*6] ##1 s.txd)
    else $error("Shift clock low phase is not six cycles.");
  a_ti_stop_start: assert property ( // RL15
    s.txState == TX_SHIFT && mode != MODE_SHIFT && $changed(s.txLeft)
    && s.txLeft == 4'h0 |-> s.ti)
    else $error("Transmit done missing at stop bit start.");
  a_ti_mode0_end: assert property ( // RL15
    $fell(s.txState == TX_SHIFT) && mode == MODE_SHIFT && !s.m0Recv
    |-> s.ti)
    else $error("Transmit done missing after shift frame.");
  a_ninth_loaded: assert property ( // RL13
    $rose(s.txState == TX_SHIFT) && mode[1] && !s.m0Recv
    |-> s.txShift[8] == $past(s.txNinth))
    else $error("Ninth bit not taken from control register.");
  a_irq_follows: assert property ( // RL18
    s.irq == $past(s.ti || s.ri))
    else $error("Interrupt request does not follow done flags.");
  a_reset_zero: assert property ( // RL17
    $past(!rstn) |-> scValue == SERIAL_CONTROL_RESET)
    else $error("Control register not zero after reset.");

  c_tx_async: cover property ($fell(s.txState == TX_SHIFT) && mode[1]);
  c_rx_async: cover property ($rose(s.ri) && mode != MODE_SHIFT);
  c_frame_err: cover property ($rose(s.fe));
  c_rx_shift: cover property ($rose(s.ri) && mode == MODE_SHIFT);

endmodule

// ===== serial_partner.sv
// Remote async station model: sends frames and captures transmitted ones.
`timescale 1ns/10ps
module serial_partner (
  input  wire logic  core_clk,
  input  wire logic  txdLine,
  output logic       rxdLine,
  output logic [9:0] gotBits,
  output int         gotCount
);
  int bitLen = 32;
  // ==========================================================================
  // Line model
  // The line idles high, so a quiet line never looks like a start bit.
  initial begin
    rxdLine = 1'b1;
    gotBits = 10'h000;
    gotCount = 0;
  end
  // Start, eight data bits LSB first, then the chosen stop level.
  task automatic send(input logic [7:0] d, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxdLine <= f[i];
      repeat (bitLen) @(posedge core_clk);
    end
    rxdLine <= 1'b1;
  endtask
  // Sample the ten bits after a start at mid bit; a late edge misaligns.
  always begin
    @(negedge txdLine);
    repeat (bitLen / 2) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (bitLen) @(posedge core_clk);
      gotBits[i] = txdLine;
    end
    gotCount++;
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the serial port with framing check.
`timescale 1ns/10ps
module testbench;
  import serial_port_pkg::*;
  logic        core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, rxdIn;
  logic        rxdOut, rxdOe, txdOut, serialIrq;
  logic [9:0]  gotBits;
  int          gotCount, err_count = 0, check_count = 0;

  serial_port_with_framing_check serial_port_with_framing_check_inst (
    .core_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .rxdIn, .rxdOut,
    .rxdOe, .txdOut, .serialIrq
  );
  serial_partner serial_partner_inst (
    .core_clk, .txdLine(txdOut), .rxdLine(rxdIn), .gotBits, .gotCount
  );

  // ==========================================================================
  // Helpers
  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Each channel is released at the edge where its ready is seen high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    resp = bresp;
    if (n == 50) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
    if (n == 50) begin
      err_count++;
      stop_test();
    end
  endtask
  // Waits out the stop bit too, since a busy transmitter drops writes.
  task automatic waitFrame(input int c0);
    int n;
    for (n = 0; n < 3000 && gotCount == c0; n++) @(posedge core_clk);
    if (n == 3000) begin
      err_count++;
      stop_test();
    end
    repeat (serial_partner_inst.bitLen) @(posedge core_clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic regsAtReset();
    rdr(SERIAL_CONTROL_ADDR);
    chk("control reset", 32'h0, rd);
    rdr(8'hb0);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(BIT_ACCESS_ADDR, 32'hc);
    chk("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    rdr(SERIAL_CONTROL_ADDR);
    chk("bit set", 32'h10, rd);
    // Enable in mode 0 starts a shift reception of the idle line.
    repeat (110) @(posedge core_clk);
    rdr(SERIAL_CONTROL_ADDR);
    chk("shift rx done", 32'h11, rd);
    rdr(DATA_ADDR);
    chk("shift rx byte", 32'hff, rd);
    wr(DATA_ADDR, 32'ha5);
    repeat (3) @(posedge core_clk);
    chk("shift pin", 32'h3, {30'h0, rxdOe, rxdOut});
    repeat (110) @(posedge core_clk);
    rdr(SERIAL_CONTROL_ADDR);
    chk("shift tx done", 32'h13, rd);
    // The partner took the shift clock for a frame; let it finish.
    repeat (300) @(posedge core_clk);
  endtask
  task automatic txMode1();
    int c;
    wr(BAUD_ADDR, 32'h0002_0002);
    wr(SERIAL_CONTROL_ADDR, 32'h40);
    c = gotCount;
    wr(DATA_ADDR, 32'ha5);
    waitFrame(c);
    chk("mode1 frame", 32'h3a5, {22'h0, gotBits});
    rdr(SERIAL_CONTROL_ADDR);
    chk("tx done", 32'h42, rd);
    chk("irq on", 32'h1, {31'h0, serialIrq});
    wr(SERIAL_CONTROL_ADDR, 32'h40);
    repeat (3) @(posedge core_clk);
    chk("irq off", 32'h0, {31'h0, serialIrq});
    // Mode 3 sends the cleared ninth bit ahead of the stop bit.
    wr(SERIAL_CONTROL_ADDR, 32'hc0);
    c = gotCount;
    wr(DATA_ADDR, 32'ha5);
    waitFrame(c);
    chk("mode3 frame", 32'h2a5, {22'h0, gotBits});
  endtask
  // Fixed mode 2 rates: a wrong divisor garbles the captured frame.
  task automatic txMode2();
    logic [7:0] pc[3] = '{8'h00, 8'h80, 8'h81};
    int len[3] = '{64, 32, 16};
    int c;
    for (int i = 0; i < 3; i++) begin
      wr(POWER_CONTROL_ADDR, {24'h0, pc[i]});
      serial_partner_inst.bitLen = len[i];
      wr(SERIAL_CONTROL_ADDR, 32'h88);
      c = gotCount;
      wr(DATA_ADDR, 32'h5a);
      waitFrame(c);
      chk("mode2 frame", 32'h35a, {22'h0, gotBits});
    end
  endtask
  task automatic rxFraming();
    serial_partner_inst.bitLen = 32;
    // Mode bits first: once the check is on, bit 7 writes the error flag.
    wr(SERIAL_CONTROL_ADDR, 32'h50);
    wr(POWER_CONTROL_ADDR, 32'h40);
    serial_partner_inst.send(8'h3c, 1'b0);
    repeat (40) @(posedge core_clk);
    rdr(SERIAL_CONTROL_ADDR);
    chk("bad stop", 32'hd1, rd);
    rdr(DATA_ADDR);
    chk("rx byte", 32'h3c, rd);
    wr(SERIAL_CONTROL_ADDR, 32'hd0);
    serial_partner_inst.send(8'h81, 1'b1);
    repeat (40) @(posedge core_clk);
    rdr(SERIAL_CONTROL_ADDR);
    chk("sticky error", 32'hd5, rd);
    wr(POWER_CONTROL_ADDR, 32'h0);
    rdr(SERIAL_CONTROL_ADDR);
    chk("bit7 as mode", 32'h55, rd);
    wr(POWER_CONTROL_ADDR, 32'h40);
    wr(SERIAL_CONTROL_ADDR, 32'h50);
    rdr(SERIAL_CONTROL_ADDR);
    chk("error cleared", 32'h50, rd);
  endtask
  task automatic rxDisabled();
    wr(SERIAL_CONTROL_ADDR, 32'h40);
    serial_partner_inst.send(8'h77, 1'b1);
    repeat (40) @(posedge core_clk);
    rdr(SERIAL_CONTROL_ADDR);
    chk("rx off flags", 32'h40, rd);
    rdr(DATA_ADDR);
    chk("rx off data", 32'h81, rd);
  endtask

  // ==========================================================================
  // Main sequence
  // Inputs start quiet; reset is held for twenty cycles.
  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    regsAtReset();
    txMode1();
    txMode2();
    rxFraming();
    rxDisabled();
    stop_test();
  end
endmodule
